// ### design/split_timer_pkg.sv
// Package: register map, field layout and reset values of the split timer
package split_timer_pkg;

    // Printed offsets are not all multiples of four: these are indexes
    localparam logic [5:0] IDX_SPLIT_CONTROL = 6'h03;
    localparam logic [5:0] IDX_COMMAND_CLEAR = 6'h04;
    localparam logic [5:0] IDX_COMMAND_SET   = 6'h05;
    localparam logic [5:0] IDX_IRQ_ENABLE    = 6'h0a;
    localparam logic [5:0] IDX_IRQ_FLAGS     = 6'h0b;
    localparam logic [5:0] IDX_DEBUG_CONTROL = 6'h0e;
    localparam logic [5:0] IDX_LOW_COUNTER   = 6'h20;
    localparam logic [5:0] IDX_HIGH_COUNTER  = 6'h21;
    localparam logic [5:0] IDX_LOW_PERIOD    = 6'h26;
    localparam logic [5:0] IDX_HIGH_PERIOD   = 6'h27;
    localparam logic [5:0] IDX_LOW_CMP0      = 6'h28;
    localparam logic [5:0] IDX_TIMER_ENABLE  = 6'h00;

    // Field positions
    localparam int POS_SPLIT_ENABLE = 0;
    localparam int POS_LOW_UNF      = 0;
    localparam int POS_HIGH_UNF     = 1;
    localparam int POS_LOW_CMP0     = 4;
    localparam int POS_DEBUG_RUN    = 0;
    localparam int POS_ENABLE       = 0;

    // Reset values
    localparam logic [7:0] RST_COUNTER = 8'h00;
    localparam logic [7:0] RST_PERIOD  = 8'hff;
    localparam logic [7:0] RST_ZERO    = 8'h00;

    // Writable bit masks
    localparam logic [7:0] MASK_IRQ     = 8'h73;
    localparam logic [7:0] MASK_CMD_RW  = 8'h03;

    // Command field encodings
    typedef enum logic [1:0] {
        CMD_NONE     = 2'h0,
        CMD_RESERVED = 2'h1,
        CMD_RESTART  = 2'h2,
        CMD_RESET    = 2'h3
    } command_t;

    localparam logic [1:0] TARGET_NONE = 2'h0;
    localparam logic [1:0] TARGET_BOTH = 2'h3;

    // Status of both counters, carried together
    typedef struct packed {
        logic [7:0] low_count;
        logic [7:0] high_count;
        logic [2:0] low_match;
    } timer_status_t;

endpackage

// ### design/dual_8bit_split_timer.sv
// Design: two independent 8-bit down counters of a split-mode timer, APB slave
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ns
// Summary of operation
// - Split enable runs two separate 8-bit timers
// - Clear register clears bits written one
// - Set register sets bits written one
// - Command field always reads back zero
// - Command codes: none, reserved, restart, reset
// - Hard reset ignored while timer enabled
// - Target code three selects both timers
// - Enable bits 4-6 held for compare interrupts, gate no output
// - Enable bits 1,0 held for underflow interrupts, gate no output
// - Low compare flag set on counter match while enabled in split mode
// - Flags clear by software writing one or by hard reset
// - High underflow flag at high bottom
// - Low underflow flag at low bottom
// - Debug run zero halts timers in break
// - Bus counter write beats count or reload
// - Low period is low TOP, resets FF
// - Counters readable writable, reset to zero
// - High period is high TOP, resets FF
// - Low compares checked continuously against counter
module dual_8bit_split_timer
    import split_timer_pkg::*;
#(
    parameter int CHANNELS = 3
) (
    input  wire logic                mclk_i,
    input  wire logic                reset_n_i,
    input  wire logic                clk_en_i,
    input  wire logic                tick_i,
    input  wire logic                debug_break_i,
    input  wire logic                psel_i,
    input  wire logic                penable_i,
    input  wire logic                pwrite_i,
    input  wire logic [7:0]          paddr_i,
    input  wire logic [31:0]         pwdata_i,
    input  wire logic [3:0]          pstrb_i,
    output logic      [31:0]         prdata_o,
    output logic                     pready_o,
    output logic                     pslverr_o,
    output logic      [CHANNELS-1:0] compare_match_o,
    output timer_status_t            status_o
);

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    logic       acc;
    logic       wr;
    logic [5:0] idx;
    logic       mapped;
    logic [7:0] wbyte;

    // Index from word address; one-cycle access, always ready
    assign acc       = psel_i & penable_i;
    assign wr        = acc & pwrite_i & pstrb_i[0];
    assign idx       = paddr_i[7:2];
    assign wbyte     = pwdata_i[7:0];
    assign pready_o  = 1'b1;
    assign pslverr_o = acc & ~mapped;

    function automatic logic is_idx(input logic [5:0] a, input logic [5:0] b);
        return a == b;
    endfunction

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    logic       enable_r;
    logic       split_enable_r;
    logic [1:0] command_target_r;
    logic [7:0] irq_enable_r;
    logic       debug_run_r;
    logic [7:0] low_period_r;
    logic [7:0] high_period_r;
    logic [7:0] low_compare_channel_r [CHANNELS];

    // Enable and mode bits
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            enable_r       <= 1'b0;
            split_enable_r <= 1'b0;
            debug_run_r    <= 1'b0;
        end else if (clk_en_i && wr) begin
            if (is_idx(idx, IDX_TIMER_ENABLE)) begin
                enable_r <= wbyte[POS_ENABLE];
            end
            if (is_idx(idx, IDX_SPLIT_CONTROL)) begin
                split_enable_r <= wbyte[POS_SPLIT_ENABLE];
            end
            if (is_idx(idx, IDX_DEBUG_CONTROL)) begin
                debug_run_r <= wbyte[POS_DEBUG_RUN];
            end
        end
    end

    // Target field via set and clear registers
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            command_target_r <= TARGET_NONE;
        end else if (clk_en_i && wr) begin
            if (is_idx(idx, IDX_COMMAND_CLEAR)) begin
                command_target_r <= command_target_r & ~(wbyte[1:0] & MASK_CMD_RW[1:0]);
            end else if (is_idx(idx, IDX_COMMAND_SET)) begin
                command_target_r <= command_target_r | (wbyte[1:0] & MASK_CMD_RW[1:0]);
            end
        end
    end

    // Interrupt enables, only the documented bits
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            irq_enable_r <= RST_ZERO;
        end else if (clk_en_i && wr && is_idx(idx, IDX_IRQ_ENABLE)) begin
            irq_enable_r <= wbyte & MASK_IRQ;
        end
    end

    // Period and compare values
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            low_period_r  <= RST_PERIOD;
            high_period_r <= RST_PERIOD;
            for (int i = 0; i < CHANNELS; i++) begin
                low_compare_channel_r[i] <= RST_ZERO;
            end
        end else if (clk_en_i && wr) begin
            if (is_idx(idx, IDX_LOW_PERIOD)) begin
                low_period_r <= wbyte;
            end
            if (is_idx(idx, IDX_HIGH_PERIOD)) begin
                high_period_r <= wbyte;
            end
            for (int i = 0; i < CHANNELS; i++) begin
                if (is_idx(idx, IDX_LOW_CMP0 + 6'(2 * i))) begin
                    low_compare_channel_r[i] <= wbyte;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------
    logic     cmd_write;
    command_t cmd;
    logic     restart;
    logic     hard_reset;

    // Command acts in the write cycle; never stored so reads zero
    assign cmd_write  = wr & (is_idx(idx, IDX_COMMAND_SET) | is_idx(idx, IDX_COMMAND_CLEAR));
    assign cmd        = command_t'(wbyte[3:2]);
    assign restart    = cmd_write & (cmd == CMD_RESTART) & (wbyte[1:0] == TARGET_BOTH);
    assign hard_reset = cmd_write & (cmd == CMD_RESET) & (wbyte[1:0] == TARGET_BOTH)
                        & ~enable_r;

    // ------------------------------------------------------------
    // Counters
    // ------------------------------------------------------------
    logic       run;
    logic       low_bottom;
    logic       high_bottom;
    logic [7:0] low_counter_r;
    logic [7:0] high_counter_r;

    // Count only enabled, in split mode, not halted by debug
    assign run         = enable_r & split_enable_r & tick_i
                         & (debug_run_r | ~debug_break_i);
    assign low_bottom  = run & (low_counter_r == RST_COUNTER);
    assign high_bottom = run & (high_counter_r == RST_COUNTER);

    // Next counter value from restart and count; bus write and hard reset handled by caller
    function automatic logic [7:0] count_next(input logic [7:0] cur, input logic [7:0] per,
                                              input logic rel, input logic go);
        if (rel) begin
            return per;
        end else if (go) begin
            return (cur == RST_COUNTER) ? per : cur - 8'h01;
        end
        return cur;
    endfunction

    // Low counter
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            low_counter_r <= RST_COUNTER;
        end else if (clk_en_i) begin
            if (hard_reset) begin
                low_counter_r <= RST_COUNTER;
            end
            else if (wr && is_idx(idx, IDX_LOW_COUNTER)) begin
                low_counter_r <= wbyte;
            end else begin
                low_counter_r <= count_next(low_counter_r, low_period_r, restart, run);
            end
        end
    end

    // High counter
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            high_counter_r <= RST_COUNTER;
        end else if (clk_en_i) begin
            if (hard_reset) begin
                high_counter_r <= RST_COUNTER;
            end
            else if (wr && is_idx(idx, IDX_HIGH_COUNTER)) begin
                high_counter_r <= wbyte;
            end else begin
                high_counter_r <= count_next(high_counter_r, high_period_r, restart, run);
            end
        end
    end

    // ------------------------------------------------------------
    // Compare and flags
    // ------------------------------------------------------------
    logic [CHANNELS-1:0] match;
    logic [7:0]          irq_flags_r;
    logic [7:0]          flag_set;
    logic [7:0]          flag_clr;

    // Continuous compare, fed out to waveform logic
    always_comb begin
        for (int i = 0; i < CHANNELS; i++) begin
            match[i] = low_counter_r == low_compare_channel_r[i];
        end
    end

    // Flag sources; compare flags only while the split timer is on,
    // else counter and compares both at zero would raise them out of reset
    always_comb begin
        flag_set                    = RST_ZERO;
        flag_set[POS_LOW_UNF]       = low_bottom;
        flag_set[POS_HIGH_UNF]      = high_bottom;
        flag_set[POS_LOW_CMP0 +: 3] = 3'(match) & {3{enable_r & split_enable_r}};
        flag_clr = (wr && is_idx(idx, IDX_IRQ_FLAGS)) ? (wbyte & MASK_IRQ) : RST_ZERO;
    end

    // Sticky flags, set beats clear
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            irq_flags_r <= RST_ZERO;
        end else if (clk_en_i) begin
            if (hard_reset) begin
                irq_flags_r <= RST_ZERO;
            end else begin
                irq_flags_r <= (irq_flags_r & ~flag_clr) | (flag_set & MASK_IRQ);
            end
        end
    end

    // Data outputs from flip-flops
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            compare_match_o <= '0;
            status_o        <= '0;
        end else if (clk_en_i) begin
            compare_match_o <= match & {CHANNELS{enable_r}};
            status_o        <= '{low_count: low_counter_r, high_count: high_counter_r,
                                 low_match: 3'(match)};
        end
    end

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    logic [7:0] rbyte;

    always_comb begin
        mapped = 1'b1;
        rbyte  = RST_ZERO;
        case (idx)
            IDX_TIMER_ENABLE:  rbyte = {7'h00, enable_r};
            IDX_SPLIT_CONTROL: rbyte = {7'h00, split_enable_r};
            IDX_COMMAND_CLEAR,
            IDX_COMMAND_SET:   rbyte = {6'h00, command_target_r};
            IDX_IRQ_ENABLE:    rbyte = irq_enable_r;
            IDX_IRQ_FLAGS:     rbyte = irq_flags_r;
            IDX_DEBUG_CONTROL: rbyte = {7'h00, debug_run_r};
            IDX_LOW_COUNTER:   rbyte = low_counter_r;
            IDX_HIGH_COUNTER:  rbyte = high_counter_r;
            IDX_LOW_PERIOD:    rbyte = low_period_r;
            IDX_HIGH_PERIOD:   rbyte = high_period_r;
            6'h28:             rbyte = low_compare_channel_r[0];
            6'h2a:             rbyte = low_compare_channel_r[1];
            6'h2c:             rbyte = low_compare_channel_r[2];
            default:           mapped = 1'b0;
        endcase
    end

    // Read data registered at the access edge is not needed; combinational word
    assign prdata_o = {24'h000000, rbyte};

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    flag_clear_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        (clk_en_i && flag_clr[POS_LOW_UNF] && !flag_set[POS_LOW_UNF]) |=> !irq_flags_r[POS_LOW_UNF])
        else $error("written one did not clear flag");
    low_unf_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        (clk_en_i && low_bottom && !hard_reset) |=> irq_flags_r[POS_LOW_UNF])
        else $error("low underflow flag not set");
    high_unf_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        (clk_en_i && high_bottom && !hard_reset) |=> irq_flags_r[POS_HIGH_UNF])
        else $error("high underflow flag not set");
    cmp_flag_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        (clk_en_i && match[0] && enable_r && split_enable_r && !hard_reset) |=> irq_flags_r[POS_LOW_CMP0])
        else $error("compare flag not set");
    no_clear_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        (clk_en_i && irq_flags_r[0] && !hard_reset && !(wr && is_idx(idx, IDX_IRQ_FLAGS)))
        |=> irq_flags_r[0])
        else $error("flag cleared by itself");
    cnt_write_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        (clk_en_i && wr && is_idx(idx, IDX_LOW_COUNTER) && !hard_reset) |=> low_counter_r == $past(wbyte))
        else $error("counter write lost");
    reset_ignored_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        (clk_en_i && enable_r && cmd_write && cmd == CMD_RESET && !run)
        |=> $stable(low_counter_r) && $stable(high_counter_r))
        else $error("hard reset taken while enabled");
    halt_debug_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        (clk_en_i && debug_break_i && !debug_run_r && !wr && !restart && !hard_reset)
        |=> $stable(low_counter_r) && $stable(high_counter_r))
        else $error("timer ran in debug halt");
    cmd_read_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        (acc && is_idx(idx, IDX_COMMAND_SET)) |-> prdata_o[3:2] == 2'h0)
        else $error("command field read nonzero");
    reload_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        (clk_en_i && low_bottom && !wr && !hard_reset) |=> low_counter_r == $past(low_period_r))
        else $error("low counter did not reload");

    // ------------------------------------------------------------
    // Checks on counting, commands and outputs
    // ------------------------------------------------------------
    // Reload, step and command effects on the counters
    high_reload_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        (clk_en_i && high_bottom && !wr && !hard_reset) |=> high_counter_r == $past(high_period_r))
        else $error("high counter did not reload");
    count_down_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        (clk_en_i && run && !low_bottom && !wr) |=> low_counter_r == $past(low_counter_r) - 8'h01)
        else $error("low counter did not step down");
    restart_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        (clk_en_i && restart) |=> low_counter_r == $past(low_period_r) && high_counter_r == $past(high_period_r))
        else $error("restart did not reload");
    hard_reset_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        (clk_en_i && hard_reset) |=> low_counter_r == RST_COUNTER && high_counter_r == RST_COUNTER)
        else $error("hard reset did not clear counters");
    split_off_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        (clk_en_i && !split_enable_r && !wr) |=> $stable(low_counter_r) && $stable(high_counter_r))
        else $error("counter ran outside split mode");

    // Set and clear registers, enables and clock enable
    set_bits_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        (clk_en_i && wr && is_idx(idx, IDX_COMMAND_SET))
        |=> command_target_r == ($past(command_target_r) | $past(wbyte[1:0])))
        else $error("set register changed other bits");
    clear_bits_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        (clk_en_i && wr && is_idx(idx, IDX_COMMAND_CLEAR))
        |=> command_target_r == ($past(command_target_r) & ~$past(wbyte[1:0])))
        else $error("clear register changed other bits");
    irq_en_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        (clk_en_i && wr && is_idx(idx, IDX_IRQ_ENABLE)) |=> irq_enable_r == ($past(wbyte) & MASK_IRQ))
        else $error("interrupt enable write wrong");
    freeze_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        !clk_en_i |=> $stable(low_counter_r) && $stable(high_counter_r) && $stable(irq_flags_r))
        else $error("state changed while clock enable low");

    // Registered outputs follow the live compare while the timer is enabled, and the counters
    compare_out_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        (clk_en_i && enable_r) |=> compare_match_o == $past(match))
        else $error("compare output wrong");
    status_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        clk_en_i |=> status_o.low_count == $past(low_counter_r) && status_o.high_count == $past(high_counter_r))
        else $error("status copy wrong");

endmodule

// ### dv/dual_8bit_split_timer_bench.sv
// Testbench: self-checking bench for the split-mode dual 8-bit timer
`timescale 1ns/1ns
module dual_8bit_split_timer_bench
    import split_timer_pkg::*;
;
    // ------------------------------------------------------------
    // Signals and design instance
    // ------------------------------------------------------------
    logic                mclk_i;
    logic                reset_n_i;
    logic                tick;
    logic                clk_en;
    logic                dbg_break;
    logic                psel;
    logic                penable;
    logic                pwrite;
    logic [7:0]          paddr;
    logic [31:0]         pwdata;
    logic [3:0]          pstrb;
    logic [31:0]         prdata_o;
    logic                pready_o;
    logic                pslverr_o;
    logic [2:0]          compare_match_o;
    timer_status_t       status_o;
    logic                last_err;
    logic [31:0]         rdata;
    int                  failures;
    int                  n_compared;

    dual_8bit_split_timer #(.CHANNELS(3)) dut_u (
        .mclk_i(mclk_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en), .tick_i(tick),
        .debug_break_i(dbg_break), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .compare_match_o(compare_match_o),
        .status_o(status_o));

    // Clock, 40 ns period
    always #20 mclk_i = ~mclk_i;

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    function automatic logic [7:0] ba(input logic [5:0] idx);
        return {idx, 2'b00};
    endfunction

    // One APB transfer, held until pready is seen high
    task automatic apb(input logic wr, input logic [5:0] idx, input logic [7:0] d);
        @(posedge mclk_i);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= ba(idx);
        pwdata  <= {24'h0, d};
        pstrb   <= wr ? 4'h1 : 4'h0;
        @(posedge mclk_i);
        penable <= 1'b1;
        do begin
            @(posedge mclk_i);
        end while (pready_o !== 1'b1);
        rdata = prdata_o;
        last_err = pslverr_o;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic rd(input logic [5:0] idx, input logic [7:0] exp, input string what);
        apb(1'b0, idx, 8'h00);
        chk(rdata, {24'h0, exp}, what);
    endtask

    // Tick held high for k sampling edges, then status allowed to settle
    task automatic ticks(input int k);
        @(posedge mclk_i);
        tick <= 1'b1;
        repeat (k) @(posedge mclk_i);
        tick <= 1'b0;
        repeat (3) @(posedge mclk_i);
    endtask

    task automatic counts(input logic [7:0] lo, input logic [7:0] hi, input string what);
        chk({24'h0, status_o.low_count}, {24'h0, lo}, what);
        chk({24'h0, status_o.high_count}, {24'h0, hi}, what);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset_regs();
        rd(IDX_LOW_PERIOD, 8'hff, "low period reset");
        rd(IDX_HIGH_PERIOD, 8'hff, "high period reset");
        rd(IDX_LOW_COUNTER, 8'h00, "low counter reset");
        rd(IDX_HIGH_COUNTER, 8'h00, "high counter reset");
        rd(IDX_IRQ_FLAGS, 8'h00, "flags reset");
        apb(1'b1, IDX_IRQ_ENABLE, 8'hff);
        rd(IDX_IRQ_ENABLE, 8'h73, "irq enable bits");
        apb(1'b0, 6'h3f, 8'h00);
        chk({31'h0, last_err}, 32'h1, "unmapped read error");
        $display("Test reset_regs done");
    endtask

    task automatic t_set_clear();
        apb(1'b1, IDX_COMMAND_SET, 8'h01);
        rd(IDX_COMMAND_SET, 8'h01, "set bit0");
        apb(1'b1, IDX_COMMAND_SET, 8'h02);
        rd(IDX_COMMAND_CLEAR, 8'h03, "set bit1 keeps bit0");
        apb(1'b1, IDX_COMMAND_CLEAR, 8'h01);
        rd(IDX_COMMAND_SET, 8'h02, "clear bit0 only");
        apb(1'b1, IDX_COMMAND_CLEAR, 8'h02);
        apb(1'b1, IDX_COMMAND_SET, 8'h0c);
        rd(IDX_COMMAND_SET, 8'h00, "command field reads 0");
        $display("Test set_clear done");
    endtask

    task automatic t_count_flags();
        apb(1'b1, IDX_LOW_PERIOD, 8'h03);
        apb(1'b1, IDX_LOW_COUNTER, 8'h02);
        apb(1'b1, IDX_HIGH_COUNTER, 8'h01);
        apb(1'b1, IDX_LOW_CMP0, 8'h01);
        apb(1'b1, IDX_LOW_CMP0 + 6'h02, 8'h00);
        apb(1'b1, IDX_LOW_CMP0 + 6'h04, 8'h03);
        apb(1'b1, IDX_TIMER_ENABLE, 8'h01);
        ticks(2);
        counts(8'h02, 8'h01, "no count without split");
        apb(1'b1, IDX_SPLIT_CONTROL, 8'h01);
        apb(1'b1, IDX_IRQ_FLAGS, 8'h73);
        rd(IDX_IRQ_FLAGS, 8'h00, "flags cleared");
        ticks(3);
        counts(8'h03, 8'hfe, "count down and reload");
        rd(IDX_IRQ_FLAGS, 8'h73, "underflow and compare");
        chk({29'h0, compare_match_o}, 32'h4, "match ch2");
        chk({29'h0, status_o.low_match}, 32'h4, "status match");
        repeat (4) @(posedge mclk_i);
        rd(IDX_IRQ_FLAGS, 8'h73, "flags stay set");
        apb(1'b1, IDX_IRQ_FLAGS, 8'h00);
        rd(IDX_IRQ_FLAGS, 8'h73, "zero write keeps flags");
        apb(1'b1, IDX_IRQ_FLAGS, 8'h03);
        rd(IDX_IRQ_FLAGS, 8'h70, "one write clears");
        $display("Test count_flags done");
    endtask

    task automatic t_debug();
        dbg_break <= 1'b1;
        ticks(2);
        counts(8'h03, 8'hfe, "halted in break");
        apb(1'b1, IDX_DEBUG_CONTROL, 8'h01);
        ticks(1);
        counts(8'h02, 8'hfd, "runs in break");
        dbg_break <= 1'b0;
        $display("Test debug done");
    endtask

    task automatic t_commands();
        apb(1'b1, IDX_COMMAND_SET, 8'h07);
        apb(1'b1, IDX_COMMAND_SET, 8'h08);
        repeat (3) @(posedge mclk_i);
        counts(8'h02, 8'hfd, "reserved or no target");
        apb(1'b1, IDX_COMMAND_CLEAR, 8'h03);
        apb(1'b1, IDX_COMMAND_SET, 8'h0b);
        repeat (3) @(posedge mclk_i);
        counts(8'h03, 8'hff, "restart reloads");
        apb(1'b1, IDX_COMMAND_CLEAR, 8'h03);
        apb(1'b1, IDX_COMMAND_SET, 8'h0f);
        rd(IDX_LOW_COUNTER, 8'h03, "reset ignored enabled");
        apb(1'b1, IDX_COMMAND_CLEAR, 8'h03);
        apb(1'b1, IDX_TIMER_ENABLE, 8'h00);
        apb(1'b1, IDX_COMMAND_SET, 8'h0f);
        rd(IDX_LOW_COUNTER, 8'h00, "hard reset low");
        rd(IDX_HIGH_COUNTER, 8'h00, "hard reset high");
        rd(IDX_LOW_PERIOD, 8'h03, "period kept");
        rd(IDX_IRQ_FLAGS, 8'h00, "hard reset clears flags");
        $display("Test commands done");
    endtask

    task automatic t_write_priority();
        apb(1'b1, IDX_COMMAND_CLEAR, 8'h03);
        apb(1'b1, IDX_TIMER_ENABLE, 8'h01);
        @(posedge mclk_i);
        tick <= 1'b1;
        apb(1'b1, IDX_LOW_COUNTER, 8'h40);
        tick <= 1'b0;
        repeat (3) @(posedge mclk_i);
        chk({24'h0, status_o.low_count}, 32'h40, "write beats count");
        $display("Test write_priority done");
    endtask

    // Clock enable low freezes the counters, high lets them run again
    task automatic t_freeze();
        clk_en <= 1'b0;
        ticks(2);
        rd(IDX_LOW_COUNTER, 8'h40, "frozen by clock enable");
        clk_en <= 1'b1;
        ticks(1);
        rd(IDX_LOW_COUNTER, 8'h3f, "runs after clock enable");
        $display("Test freeze done");
    endtask

    // ------------------------------------------------------------
    // Closing, watchdog and main sequence
    // ------------------------------------------------------------
    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Watchdog, well beyond the expected few hundred cycles
    initial begin
        #(40 * 5000);
        failures++;
        $display("Error at %0t: watchdog expired", $time);
        wrap_up();
    end

    initial begin
        mclk_i = 1'b0; reset_n_i = 1'b0; tick = 1'b0; dbg_break = 1'b0;
        psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0; pstrb = 4'h0;
        failures = 0; n_compared = 0; last_err = 1'b0;
        clk_en = 1'b1;
        repeat (12) @(posedge mclk_i);
        reset_n_i <= 1'b1;
        t_reset_regs();
        t_set_clear();
        t_count_flags();
        t_debug();
        t_commands();
        t_write_priority();
        t_freeze();
        wrap_up();
    end
endmodule
